/* shared/flash_ctrl_params.svh */
// Constants for the flash driver mode and trigger control block.
`ifndef FLASH_CTRL_PARAMS_SVH
`define FLASH_CTRL_PARAMS_SVH

// Clock period and the microsecond tick derived from it.
`define CLK_PERIOD_NS 25
`define TICK_US 1
`define NS_PER_US 1000

// Serial logic start-up time in microseconds; the maximum allowed is 500.
`define SERIAL_START_US 250
// Flash timeout in milliseconds.
`define FLASH_TIMEOUT_MS 850

// Register indices; byte address is four times the index.
`define IDX_FLASH 8'h02
`define IDX_TORCH 8'h03
`define IDX_CTRL 8'h04
`define IDX_STATUS 8'h05

// Control register fields.
`define CTRL_OUTPUT_ON 0
`define CTRL_TRIG_EN 1
`define CTRL_TRIG_LEVEL 2
// Torch register fields.
`define TORCH_DETECT_EN 3
// Status register fields.
`define ST_SERIAL_MODE 0
`define ST_SERIAL_READY 1
`define ST_LED_TWO 2
`define ST_BOOST 3
`define ST_FLASH 4
`define ST_TIMEOUT 5

// Flash codes: current is 200 mA plus 20 mA per step.
`define FLASH_MAX_ONE 4'hF
`define FLASH_MAX_TWO 4'hA
`define FLASH_DEF_ONE 4'hF
`define FLASH_DEF_TWO 4'h6
// Torch codes: current is 60 mA plus 20 mA per step.
`define TORCH_MAX 3'h5
`define TORCH_DEF 3'h1

`endif

/* shared/flash_ctrl_pkg.sv */
// Types shared by the flash driver mode and trigger control block.
package flash_ctrl_pkg;

    // Flash sequencer states, one-hot.
    typedef enum logic [1:0] {
        FL_IDLE = 2'b01,
        FL_ON = 2'b10
    } flash_state_e;

    // Complete state of the control block.
    typedef struct packed {
        logic [5:0] tick_cnt;
        logic tick;
        logic [8:0] start_cnt;
        logic serial_ready;
        flash_state_e fl_state;
        logic [19:0] flash_cnt;
        logic trig_prev;
        logic ramp_prev;
        logic [3:0] flash_code;
        logic [2:0] torch_code;
        logic detect_en;
        logic out_on;
        logic trig_en;
        logic trig_level;
        logic led_two;
        logic boost;
        logic timeout_seen;
        logic [31:0] prdata;
    } ctrl_state_s;

    // State of a two-stage synchroniser bank.
    typedef struct packed {
        logic [6:0] stage1;
        logic [6:0] stage2;
    } sync_state_s;

endpackage : flash_ctrl_pkg

/* core/pin_sync.sv */
// Two flip-flop synchroniser for the asynchronous pins of the block.
`timescale 1ns/1ps
`default_nettype none
module pin_sync
    import flash_ctrl_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [6:0] raw,
    output logic [6:0] synced
);

    sync_state_s s_reg; // Both stages of the bank.
    sync_state_s s_next; // Next value of both stages.

    // The first stage feeds only the second stage.
    always_comb begin
        s_next = s_reg;
        s_next.stage1 = raw;
        s_next.stage2 = s_reg.stage1;
    end

    // Registers clear to low so no pin looks active during reset.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign synced = s_reg.stage2;

endmodule : pin_sync
`default_nettype wire

/* core/flash_mode_ctrl.sv */
// Mode select, pin routing, trigger sequencer and APB registers of the flash driver.
// Function
// - Boost sticks until output disabled
// - One LED: 200-500 mA, default 500
// - Two LEDs: 200-400 mA, default 320
// - Torch current 60-160 mA, 20 mA steps
// - Select low simple, high serial
// - Shared pins become serial or enables
// - Enables drive flash, torch, indicator
// - Shared pulldowns on only in simple
// - Trigger needs serial, output and enable
// - Level select bit picks level/edge
// - Edge mode: only timer or disarm ends flash
// - Level mode: fall or timer ends
// - Trigger pulldown on in serial mode
// - Simple mode: trigger pin shows LED count
// - Sample LED voltage at 80 mA
// - High voltage means two LEDs, cap
`timescale 1ns/1ps
`default_nettype none
`include "flash_ctrl_params.svh"
module flash_mode_ctrl
    import flash_ctrl_pkg::*;
#(
    // Flash timeout in microsecond ticks; shorten for simulation.
    parameter int FLASH_TIMEOUT_TICKS = `FLASH_TIMEOUT_MS * `NS_PER_US / `TICK_US
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic mode_select_pin,
    input wire logic shared_clock_or_enable_a_pin,
    input wire logic shared_data_or_enable_b_pin,
    input wire logic trigger_pin_in,
    output logic trigger_pin_out,
    output logic trigger_pin_oe,
    input wire logic need_boost_in,
    input wire logic ramp_at_80ma_in,
    input wire logic led_voltage_high_in,
    output logic serial_mode,
    output logic serial_ready,
    output logic serial_clock,
    output logic serial_data,
    output logic simple_enable_a,
    output logic simple_enable_b,
    output logic shared_pulldown_en,
    output logic trigger_pulldown_en,
    output logic flash_on,
    output logic torch_on,
    output logic indicator_on,
    output logic [3:0] flash_code,
    output logic [2:0] torch_code,
    output logic led_two_detected,
    output logic boost_mode,
    output logic pass_switch_on
);

    // Cycles per microsecond tick and the start-up count in ticks.
    localparam int TICK_CYCLES = `TICK_US * `NS_PER_US / `CLK_PERIOD_NS;
    localparam logic [5:0] TICK_LAST = 6'(TICK_CYCLES - 1);
    localparam logic [8:0] START_LAST = 9'(`SERIAL_START_US / `TICK_US - 1);
    localparam logic [19:0] FLASH_LAST = 20'(FLASH_TIMEOUT_TICKS - 1);

    // Reset state: single LED defaults, serial logic not ready.
    localparam ctrl_state_s RESET_STATE = '{
        tick_cnt: 6'h00, tick: 1'b0, start_cnt: 9'h000, serial_ready: 1'b0,
        fl_state: FL_IDLE, flash_cnt: 20'h00000, trig_prev: 1'b0, ramp_prev: 1'b0,
        flash_code: `FLASH_DEF_ONE, torch_code: `TORCH_DEF, detect_en: 1'b1,
        out_on: 1'b0, trig_en: 1'b0, trig_level: 1'b0, led_two: 1'b0, boost: 1'b0,
        timeout_seen: 1'b0, prdata: 32'h00000000
    };

    ctrl_state_s r_reg; // Registered state of the block.
    ctrl_state_s r_next; // Next state of the block.
    logic [6:0] pins; // Synchronised pin levels.
    logic sel; // Serial mode selected.
    logic pin_a; // Synchronised shared pin A.
    logic pin_b; // Synchronised shared pin B.
    logic trig; // Synchronised trigger pin.
    logic need_boost; // Synchronised headroom comparator.
    logic ramp; // Synchronised 80 mA ramp marker.
    logic vhigh; // Synchronised LED voltage comparator.
    logic trig_rise; // Trigger rising edge this cycle.
    logic ramp_rise; // Ramp marker rising edge this cycle.
    logic armed; // Trigger may start a flash.
    logic flash_active; // Flash sequencer is running.
    logic output_active; // Flash or torch current is flowing.
    logic wr_access; // APB write in its access phase.
    logic setup_rd; // APB read in its setup phase.
    logic mapped; // Address hits a register.

    // Byte address of a register index.
    function automatic logic [7:0] reg_addr(input logic [7:0] idx);
        reg_addr = {idx[5:0], 2'b00};
    endfunction : reg_addr

    // Limit a code to a ceiling.
    function automatic logic [3:0] clamp(input logic [3:0] code, input logic [3:0] top);
        clamp = (code > top) ? top : code;
    endfunction : clamp

    // All pins from outside the clock domain pass two flip-flops first.
    pin_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .raw({led_voltage_high_in, ramp_at_80ma_in, need_boost_in, trigger_pin_in,
              shared_data_or_enable_b_pin, shared_clock_or_enable_a_pin, mode_select_pin}),
        .synced(pins)
    );

    assign sel = pins[0];
    assign pin_a = pins[1];
    assign pin_b = pins[2];
    assign trig = pins[3];
    assign need_boost = pins[4];
    assign ramp = pins[5];
    assign vhigh = pins[6];
    assign trig_rise = trig & ~r_reg.trig_prev;
    assign ramp_rise = ramp & ~r_reg.ramp_prev;
    // Trigger is live only in serial mode with both control bits set.
    assign armed = sel & r_reg.serial_ready & r_reg.out_on & r_reg.trig_en;
    assign flash_active = (r_reg.fl_state == FL_ON);

    assign mapped = (paddr == reg_addr(`IDX_FLASH)) || (paddr == reg_addr(`IDX_TORCH)) ||
                    (paddr == reg_addr(`IDX_CTRL)) || (paddr == reg_addr(`IDX_STATUS));
    assign wr_access = psel & penable & pwrite & mapped;
    assign setup_rd = psel & ~penable & ~pwrite;

    // Next-state logic for timers, sequencer, detection and registers.
    always_comb begin
        r_next = r_reg;
        // Microsecond tick divider keeps the long counters narrow.
        r_next.tick = 1'b0;
        if (r_reg.tick_cnt == TICK_LAST) begin
            r_next.tick_cnt = 6'h00;
            r_next.tick = 1'b1;
        end else begin
            r_next.tick_cnt = r_reg.tick_cnt + 6'h01;
        end
        // Serial start-up delay restarts whenever select is low.
        if (!sel) begin
            r_next.start_cnt = 9'h000;
            r_next.serial_ready = 1'b0;
        end else if (!r_reg.serial_ready && r_reg.tick) begin
            if (r_reg.start_cnt == START_LAST) begin
                r_next.serial_ready = 1'b1;
            end else begin
                r_next.start_cnt = r_reg.start_cnt + 9'h001;
            end
        end
        r_next.trig_prev = trig;
        r_next.ramp_prev = ramp;
        // Register writes take effect in the access cycle.
        if (wr_access) begin
            if (paddr == reg_addr(`IDX_FLASH)) begin
                // Writes beyond the ceiling of the detected load are clipped.
                r_next.flash_code = clamp(pwdata[3:0],
                    r_reg.led_two ? `FLASH_MAX_TWO : `FLASH_MAX_ONE);
            end else if (paddr == reg_addr(`IDX_TORCH)) begin
                r_next.torch_code = 3'(clamp({1'b0, pwdata[2:0]}, {1'b0, `TORCH_MAX}));
                r_next.detect_en = pwdata[`TORCH_DETECT_EN];
            end else if (paddr == reg_addr(`IDX_CTRL)) begin
                r_next.out_on = pwdata[`CTRL_OUTPUT_ON];
                r_next.trig_en = pwdata[`CTRL_TRIG_EN];
                r_next.trig_level = pwdata[`CTRL_TRIG_LEVEL];
            end else if (pwdata[`ST_TIMEOUT]) begin
                // Writing one clears the timeout flag; a new timeout below wins.
                r_next.timeout_seen = 1'b0;
            end
        end
        // Flash sequencer.
        case (r_reg.fl_state)
            FL_IDLE: begin
                if (armed && trig_rise) begin
                    r_next.fl_state = FL_ON;
                    r_next.flash_cnt = 20'h00000;
                end
            end
            FL_ON: begin
                // A new rising edge is not looked at here, so the timer runs on.
                if (!armed) begin
                    r_next.fl_state = FL_IDLE;
                end else if (r_reg.trig_level && !trig) begin
                    r_next.fl_state = FL_IDLE;
                end else if (r_reg.tick) begin
                    if (r_reg.flash_cnt == FLASH_LAST) begin
                        r_next.fl_state = FL_IDLE;
                        r_next.timeout_seen = 1'b1;
                    end else begin
                        r_next.flash_cnt = r_reg.flash_cnt + 20'h00001;
                    end
                end
            end
            default: begin
                r_next.fl_state = FL_IDLE;
            end
        endcase
        // LED count is taken when the ramp passes 80 mA.
        if (ramp_rise && r_reg.detect_en) begin
            r_next.led_two = vhigh;
            if (vhigh != r_reg.led_two) begin
                r_next.flash_code = vhigh ? `FLASH_DEF_TWO : `FLASH_DEF_ONE;
            end
        end
        // Boost is latched until the output is switched off.
        if (!output_active) begin
            r_next.boost = 1'b0;
        end else if (need_boost) begin
            r_next.boost = 1'b1;
        end
        // Read data is captured in the setup cycle so prdata comes from a flop.
        if (setup_rd) begin
            r_next.prdata = 32'h00000000;
            if (paddr == reg_addr(`IDX_FLASH)) begin
                r_next.prdata[3:0] = r_reg.flash_code;
            end else if (paddr == reg_addr(`IDX_TORCH)) begin
                r_next.prdata[2:0] = r_reg.torch_code;
                r_next.prdata[`TORCH_DETECT_EN] = r_reg.detect_en;
            end else if (paddr == reg_addr(`IDX_CTRL)) begin
                r_next.prdata[`CTRL_OUTPUT_ON] = r_reg.out_on;
                r_next.prdata[`CTRL_TRIG_EN] = r_reg.trig_en;
                r_next.prdata[`CTRL_TRIG_LEVEL] = r_reg.trig_level;
            end else if (paddr == reg_addr(`IDX_STATUS)) begin
                r_next.prdata[`ST_SERIAL_MODE] = sel;
                r_next.prdata[`ST_SERIAL_READY] = r_reg.serial_ready;
                r_next.prdata[`ST_LED_TWO] = r_reg.led_two;
                r_next.prdata[`ST_BOOST] = r_reg.boost;
                r_next.prdata[`ST_FLASH] = flash_active;
                r_next.prdata[`ST_TIMEOUT] = r_reg.timeout_seen;
            end
        end
    end

    // Single register stage for the whole state.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_reg <= RESET_STATE;
        end else begin
            r_reg <= r_next;
        end
    end

    // APB answers in the first access cycle; unmapped addresses fail.
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign prdata = r_reg.prdata;

    // Shared pins are routed by the synchronised select level.
    assign serial_mode = sel;
    assign serial_ready = r_reg.serial_ready;
    assign serial_clock = sel & pin_a;
    assign serial_data = sel & pin_b;
    assign simple_enable_a = ~sel & pin_a;
    assign simple_enable_b = ~sel & pin_b;
    assign shared_pulldown_en = ~sel;
    assign trigger_pulldown_en = sel;

    // Open-drain count report: a pulled-up high means two LEDs.
    assign trigger_pin_out = 1'b0;
    assign trigger_pin_oe = ~sel & ~r_reg.led_two;

    // Enable B with A gives flash, B alone torch, A alone the indicator.
    assign flash_on = sel ? flash_active : (simple_enable_a & simple_enable_b);
    assign torch_on = simple_enable_b & ~simple_enable_a;
    assign indicator_on = simple_enable_a & ~simple_enable_b;
    assign output_active = flash_on | torch_on;
    assign flash_code = r_reg.flash_code;
    assign torch_code = r_reg.torch_code;
    assign led_two_detected = r_reg.led_two;
    assign boost_mode = r_reg.boost;
    assign pass_switch_on = output_active & ~r_reg.boost;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Select rising edge followed by start-up quiet time.
    sequence s_select_rise;
        sel && !$past(sel);
    endsequence
    sequence s_not_ready_8;
        !serial_ready [*8];
    endsequence

    // The host must see a quiet start-up window after the select pin goes high.
    a_startup_quiet: assert property (s_select_rise |-> s_not_ready_8)
        else $error("serial ready too early after select");

    // Ready may only come from a full start-up count, never from a stale flop.
    a_ready_count: assert property (
        $rose(serial_ready) |-> r_reg.start_cnt == START_LAST)
        else $error("serial ready without full start-up count");

    // Falling back to pass mode under load would glitch the LED current.
    a_boost_sticky: assert property (boost_mode && output_active |=> boost_mode)
        else $error("boost left while output active");

    // The flash ceiling follows the detected load at all times.
    a_flash_range: assert property (
        flash_code <= (led_two_detected ? `FLASH_MAX_TWO : `FLASH_MAX_ONE))
        else $error("flash code above ceiling");

    a_torch_range: assert property (torch_code <= `TORCH_MAX)
        else $error("torch code above ceiling");

    // Serial outputs stay quiet while the pins serve as enables.
    a_pin_routing: assert property (
        !serial_mode |-> !serial_clock && !serial_data && shared_pulldown_en)
        else $error("shared pins misrouted in simple mode");

    a_trigger_gated: assert property (!flash_active && !armed |=> !flash_active)
        else $error("flash started while trigger disarmed");

    // In edge mode, while armed, only a timer tick may end the flash.
    a_edge_hold: assert property (
        flash_active && armed && !r_reg.trig_level && !r_reg.tick |=> flash_active)
        else $error("edge flash ended before timer");

    a_level_end: assert property (
        flash_active && r_reg.trig_level && !trig |=> !flash_active)
        else $error("level flash not ended by falling trigger");

    a_no_restart: assert property (
        flash_active && $past(flash_active) |-> r_reg.flash_cnt >= $past(r_reg.flash_cnt))
        else $error("flash timer restarted");

    a_count_report: assert property (
        !serial_mode |-> trigger_pin_oe == !led_two_detected)
        else $error("trigger pin count report wrong");

    a_detect_sample: assert property (
        ramp_rise && r_reg.detect_en |=> led_two_detected == $past(vhigh))
        else $error("LED count not sampled at ramp marker");

endmodule : flash_mode_ctrl
`default_nettype wire

/* tb/strobe_host_model.sv */
// Far side of the flash block: camera strobe line and serial host clock.
`timescale 1ns/1ps
`default_nettype none
module strobe_host_model (
    input wire logic strobe_drive,
    input wire logic strobe_level,
    input wire logic trigger_pin_oe,
    input wire logic trigger_pulldown_en,
    input wire logic frame_en,
    output logic trigger_wire,
    output logic link_clock
);
    // Resolve the strobe wire; a released camera leaves the pulldown or the board pullup.
    always_comb begin
        if (trigger_pin_oe) begin
            // The block pulls the wire low, which beats the board pullup.
            trigger_wire = 1'b0;
        end else if (strobe_drive) begin
            // The camera drives its strobe level.
            trigger_wire = strobe_level;
        end else begin
            // Nobody drives, so the pulldown or the pullup sets the level.
            trigger_wire = !trigger_pulldown_en;
        end
    end
    // Host clock of 200 ns period runs only inside a frame and rests high between frames.
    initial begin
        link_clock = 1'b1;
        forever begin
            #100;
            link_clock = frame_en ? !link_clock : 1'b1;
        end
    end
endmodule : strobe_host_model
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench for the flash mode and trigger control block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import flash_ctrl_pkg::*;
    localparam int TICKS = 20; // Shortened flash timeout, in microsecond ticks.
    localparam int FLASH_CYC = TICKS * 40; // Expected flash length in clock cycles.
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, err;
    logic mode_sel = 1'b0, en_a = 1'b0, en_b = 1'b0; // Board select level and enables.
    logic cam_drive = 1'b0, cam_level = 1'b0, frame_en = 1'b0;
    logic need_boost = 1'b0, ramp80 = 1'b0, vled_high = 1'b0;
    logic trig_wire, link_clk, trig_out, trig_oe, pin_a, pin_b;
    logic serial_mode, serial_ready, serial_clock, serial_data, simple_enable_a;
    logic simple_enable_b, shared_pulldown_en, trigger_pulldown_en, flash_on, torch_on;
    logic indicator_on, led_two_detected, boost_mode, pass_switch_on;
    logic [3:0] flash_code;
    logic [2:0] torch_code;
    int n_fail = 0, checked = 0, len;
    // Pin A carries the host clock and pin B a high data level in serial mode; both carry the enables otherwise.
    assign pin_a = mode_sel ? link_clk : en_a;
    assign pin_b = mode_sel ? 1'b1 : en_b;
    initial begin
        forever #12.5 pclk = !pclk;
    end
    flash_mode_ctrl #(.FLASH_TIMEOUT_TICKS(TICKS)) dut_u (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .mode_select_pin(mode_sel),
        .shared_clock_or_enable_a_pin(pin_a), .shared_data_or_enable_b_pin(pin_b),
        .trigger_pin_in(trig_wire), .trigger_pin_out(trig_out), .trigger_pin_oe(trig_oe),
        .need_boost_in(need_boost), .ramp_at_80ma_in(ramp80), .led_voltage_high_in(vled_high),
        .serial_mode(serial_mode), .serial_ready(serial_ready), .serial_clock(serial_clock),
        .serial_data(serial_data), .simple_enable_a(simple_enable_a),
        .simple_enable_b(simple_enable_b), .shared_pulldown_en(shared_pulldown_en),
        .trigger_pulldown_en(trigger_pulldown_en), .flash_on(flash_on), .torch_on(torch_on),
        .indicator_on(indicator_on), .flash_code(flash_code), .torch_code(torch_code),
        .led_two_detected(led_two_detected), .boost_mode(boost_mode),
        .pass_switch_on(pass_switch_on));
    strobe_host_model partner_u (.strobe_drive(cam_drive), .strobe_level(cam_level),
        .trigger_pin_oe(trig_oe), .trigger_pulldown_en(trigger_pulldown_en),
        .frame_en(frame_en), .trigger_wire(trig_wire), .link_clock(link_clk));
    // Print the counts and the verdict, then stop.
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_of_test
    // Compare one value against its expectation.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk
    // One APB transfer; the request holds until pready is seen high at a rising edge.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            chk(0, 1, "no pready");
            end_of_test();
        end
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Wait a bounded number of cycles for a level; the cycles taken come back in len.
    task automatic wait_lvl(ref logic s, input logic v, input int lim);
        for (len = 0; len < lim; len++) begin
            @(posedge pclk);
            if (s === v) return;
        end
        chk(0, 1, "wait ran out");
        end_of_test();
    endtask : wait_lvl
    // Simple mode: pin routing, pulldowns, enable decode and reset register values.
    task automatic t_simple();
        apb(1'b0, 8'h08, 0);
        chk(q, 32'hF, "flash reset code");
        apb(1'b0, 8'h0C, 0);
        chk(q, 32'h9, "torch reset");
        apb(1'b0, 8'h40, 0);
        chk(err, 1'b1, "unmapped error");
        chk(q, 32'h0, "unmapped read");
        chk({shared_pulldown_en, trigger_pulldown_en}, 2'b10, "simple pulldowns");
        chk({serial_mode, trig_wire}, 2'b00, "simple mode, one LED");
        chk(trig_out, 1'b0, "count pin drives low only");
        for (int k = 0; k < 4; k++) begin
            {en_a, en_b} <= k[1:0];
            repeat (5) @(posedge pclk);
            chk({simple_enable_a, simple_enable_b, serial_clock}, {k[1:0], 1'b0}, "pins");
            chk({flash_on, torch_on, indicator_on}, {k == 3, k == 1, k == 2}, "decode");
        end
        {en_a, en_b} <= 2'b00;
    endtask : t_simple
    // LED count detection at the 80 mA point, current ceilings and reloaded defaults.
    task automatic t_detect(input logic two);
        vled_high <= two;
        ramp80 <= 1'b1;
        repeat (6) @(posedge pclk);
        ramp80 <= 1'b0;
        chk(led_two_detected, two, "led count");
        chk(flash_code, two ? 4'h6 : 4'hF, "count default");
        if (!mode_sel) chk(trig_wire, two, "count on strobe pin");
        apb(1'b1, 8'h08, 32'hF);
        apb(1'b0, 8'h08, 0);
        chk(q, two ? 32'hA : 32'hF, "flash ceiling");
        apb(1'b1, 8'h08, 32'h0);
        @(posedge pclk);
        chk(flash_code, 4'h0, "flash floor");
    endtask : t_detect
    // Detection switched off keeps the count; torch range is clamped at code 5.
    task automatic t_torch();
        apb(1'b1, 8'h0C, 32'h0);
        vled_high <= 1'b0;
        ramp80 <= 1'b1;
        repeat (6) @(posedge pclk);
        ramp80 <= 1'b0;
        chk(led_two_detected, 1'b1, "detect disabled");
        apb(1'b1, 8'h0C, 32'hF);
        @(posedge pclk);
        chk(torch_code, 3'h5, "torch ceiling");
        apb(1'b1, 8'h0C, 32'h8);
        @(posedge pclk);
        chk(torch_code, 3'h0, "torch floor");
    endtask : t_torch
    // Serial mode start-up; the host waits for ready before any register traffic.
    task automatic t_serial();
        mode_sel <= 1'b1;
        wait_lvl(serial_ready, 1'b1, 25000);
        chk(len > 9900 && len < 20001, 1, "start-up time");
        chk({shared_pulldown_en, trigger_pulldown_en}, 2'b01, "serial pulldowns");
        chk(trig_wire, 1'b0, "released strobe pulled down");
        frame_en <= 1'b1;
        wait_lvl(serial_clock, 1'b0, 40);
        wait_lvl(serial_clock, 1'b1, 40);
        chk({serial_data, simple_enable_a}, 2'b10, "serial routing");
        frame_en <= 1'b0;
    endtask : t_serial
    // Strobe pulse of given width and optional retrigger; len returns the flash cycles left after them.
    task automatic strobe(input int width, input int retrig_at);
        cam_drive <= 1'b1;
        cam_level <= 1'b1;
        wait_lvl(flash_on, 1'b1, 10);
        repeat (width) @(posedge pclk);
        cam_level <= 1'b0;
        if (retrig_at > 0) begin
            repeat (retrig_at) @(posedge pclk);
            cam_level <= 1'b1;
            need_boost <= 1'b1;
            repeat (10) @(posedge pclk);
            cam_level <= 1'b0;
            need_boost <= 1'b0;
            repeat (10) @(posedge pclk);
            chk({boost_mode, pass_switch_on}, 2'b10, "boost latched");
        end
        wait_lvl(flash_on, 1'b0, 2 * FLASH_CYC);
        cam_drive <= 1'b0;
    endtask : strobe
    // Edge, level and unarmed strobe handling plus the timeout flag.
    task automatic t_trigger();
        apb(1'b1, 8'h10, 32'h1);
        cam_drive <= 1'b1;
        cam_level <= 1'b1;
        repeat (20) @(posedge pclk);
        chk(flash_on, 1'b0, "unarmed strobe");
        cam_level <= 1'b0;
        cam_drive <= 1'b0;
        repeat (5) @(posedge pclk);
        apb(1'b1, 8'h10, 32'h3);
        strobe(5, 300);
        chk(len > FLASH_CYC - 400 && len < FLASH_CYC - 250, 1, "edge length");
        repeat (5) @(posedge pclk);
        chk(boost_mode, 1'b0, "boost re-evaluated");
        apb(1'b0, 8'h14, 0);
        chk(q & 32'h23, 32'h23, "timeout status");
        apb(1'b1, 8'h14, 32'h20);
        apb(1'b0, 8'h14, 0);
        chk(q[5], 1'b0, "timeout cleared");
        apb(1'b1, 8'h10, 32'h7);
        strobe(100, 0);
        chk(len < 8, 1, "level end on fall");
        cam_drive <= 1'b1;
        cam_level <= 1'b1;
        wait_lvl(flash_on, 1'b1, 10);
        wait_lvl(flash_on, 1'b0, 2 * FLASH_CYC);
        chk(len > FLASH_CYC - 50 && len < FLASH_CYC + 50, 1, "level timeout");
        cam_level <= 1'b0;
        cam_drive <= 1'b0;
    endtask : t_trigger
    // Main sequence.
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        t_simple();
        t_detect(1'b1);
        t_torch();
        t_serial();
        t_detect(1'b0);
        t_trigger();
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
